// ==== include/flash_status_defines.vh ====
`ifndef FLASH_STATUS_DEFINES_VH
`define FLASH_STATUS_DEFINES_VH

// wishbone register offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_ADDR        4'h4
`define REG_DATA        4'h8
`define REG_STAT        4'hc

// control register fields
`define CTRL_START      0
`define CTRL_MODE       1
`define CTRL_ABORT      2

// status register fields
`define STAT_BUSY       0
`define STAT_DONE       1
`define STAT_FAIL       2
`define STAT_RDY        3
`define STAT_SUSP       4
`define STAT_READ_LO    8

// status bit positions on the flash data bus
`define POLL_BIT        7
`define TOG1_BIT        6
`define TIMEOUT_BIT     5
`define TOG2_BIT        2

// reset command data
`define RESET_CMD       8'hf0

// bus timing at 50 MHz: access time; read and write strobes stay low ACCESS_CYC + 3 cycles
`define CLK_MHZ         50
`define ACCESS_NS       100
`define ACCESS_CYC      (((`ACCESS_NS) * (`CLK_MHZ) + 999) / 1000)
`define CNT_W           4

`endif

// ==== rtl/flash_bus_cycle.v ====
`include "flash_status_defines.vh"
`default_nettype none

// ****************************************************************
// one read or write cycle on the flash pins
// ****************************************************************
module flash_bus_cycle
(
  input  wire        clk,         // system clock
  input  wire        nrst,        // async reset, active low
  input  wire        go,          // start a cycle, one pulse
  input  wire        wr,          // 1 write, 0 read
  input  wire [20:0] addr,        // flash address
  input  wire [7:0]  wdata,       // write data
  input  wire [7:0]  dq_sync,     // synchronised data pins
  output reg         done,        // cycle finished, one pulse
  output reg  [7:0]  rdata,       // captured read data
  output reg  [20:0] a_out,       // address pins
  output reg  [7:0]  dq_out,      // data out
  output reg         dq_oe,       // data drive enable
  output reg         ce_n,        // chip enable
  output reg         oe_n,        // output enable
  output reg         we_n         // write strobe
);

  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_ACT  = 3'h2;
  localparam [2:0] S_END  = 3'h4;

  reg [2:0]        state_reg;
  reg [`CNT_W-1:0] cnt_reg;
  wire [31:0]      load_full = `ACCESS_CYC + 2; // count loaded at strobe fall

  // strobe timing: ce/oe or ce/we low for ACCESS_CYC + 3 cycles, then capture
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= {`CNT_W{1'b0}};
      done      <= 1'b0;
      rdata     <= 8'h00;
      a_out     <= 21'h00000;
      dq_out    <= 8'h00;
      dq_oe     <= 1'b0;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (go)
          begin
            a_out     <= addr;
            dq_out    <= wdata;
            dq_oe     <= wr;
            ce_n      <= 1'b0;
            oe_n      <= wr;
            we_n      <= ~wr;
            cnt_reg   <= load_full[`CNT_W-1:0];
            state_reg <= S_ACT;
          end
        end
        S_ACT:
        begin
          if (cnt_reg == {`CNT_W{1'b0}})
          begin
            rdata     <= dq_sync; // data already held two cycles
            ce_n      <= 1'b1;    // rising strobe ends the cycle
            oe_n      <= 1'b1;
            we_n      <= 1'b1;
            state_reg <= S_END;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        S_END:
        begin
          dq_oe     <= 1'b0;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/flash_status_poller.v ====
// Behaviour
// - every status read presents the address being programmed
// - erase status reads use an address inside a selected sector
// - poll bit may change before low bits; take data from a later read
// - toggle check starts with two reads; no change means complete
// - toggling with timeout flag high: recheck, still toggling means failure
// - a restarted check begins again from its first step
// - after failure the host writes the reset command F0
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`include "flash_status_defines.vh"
`default_nettype none

module flash_status_poller
(
  input  wire        CLK,        // 50 MHz clock
  input  wire        NRST,       // async reset, active low
  input  wire [3:0]  ADR_I,      // wishbone address
  input  wire [31:0] DAT_I,      // wishbone write data
  input  wire [3:0]  SEL_I,      // wishbone byte selects
  input  wire        WE_I,       // wishbone write enable
  input  wire        CYC_I,      // wishbone cycle
  input  wire        STB_I,      // wishbone strobe
  output reg  [31:0] DAT_O,      // wishbone read data
  output reg         ACK_O,      // wishbone acknowledge
  output wire [20:0] FA,         // flash address pins
  output wire [7:0]  FDQ_O,      // flash data out
  output wire        FDQ_OE,     // flash data drive enable
  input  wire [7:0]  FDQ_I,      // flash data in
  output wire        FCE_N,      // flash chip enable
  output wire        FOE_N,      // flash output enable
  output wire        FWE_N,      // flash write strobe
  input  wire        READY_BUSY_N // open-drain ready/busy, pulled up
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_RD1   = 7'h02;
  localparam [6:0] S_RD2   = 7'h04;
  localparam [6:0] S_RECHK = 7'h08;
  localparam [6:0] S_RST   = 7'h10;
  localparam [6:0] S_FINAL = 7'h20;
  localparam [6:0] S_WAIT  = 7'h40;
  reg [6:0]  state_reg;
  reg        mode_reg;      // 0 toggle method, 1 polling method
  reg [20:0] addr_reg;      // valid status address
  reg [7:0]  data_reg;      // expected programmed datum
  reg        busy_reg;
  reg        done_reg;
  reg        fail_reg;
  reg        susp_reg;      // toggle two toggling while one stopped
  reg [7:0]  first_reg;     // previous status read
  reg [7:0]  last_reg;      // final array read
  reg        go_reg;
  reg        wr_reg;
  reg [7:0]  dq_meta_reg;
  reg [7:0]  dq_sync_reg;
  reg [1:0]  rb_sync_reg;
  reg        start_pulse;   // start bit written
  reg        abort_pulse;   // abort bit written while busy
  wire       cyc_done;
  wire [7:0] cyc_data;
  wire       tog_one;       // toggle bit one changed between reads
  wire       tog_two;       // toggle bit two changed between reads
  // toggle compare: bit differs between two reads
  function toggled;
    input [7:0] a;
    input [7:0] b;
    input integer pos;
    begin
      toggled = a[pos] ^ b[pos];
    end
  endfunction
  // toggle flags of the newest read against the one before
  assign tog_one = toggled(first_reg, cyc_data, `TOG1_BIT);
  assign tog_two = toggled(first_reg, cyc_data, `TOG2_BIT);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      dq_meta_reg <= 8'h00;
      dq_sync_reg <= 8'h00;
      rb_sync_reg <= 2'h3;
    end
    else
    begin
      dq_meta_reg <= FDQ_I;
      dq_sync_reg <= dq_meta_reg;
      rb_sync_reg <= {rb_sync_reg[0], READY_BUSY_N};
    end
  end

  flash_bus_cycle u_cyc
  (
    .clk     (CLK),
    .nrst    (NRST),
    .go      (go_reg),
    .wr      (wr_reg),
    .addr    (addr_reg),
    .wdata   (`RESET_CMD),
    .dq_sync (dq_sync_reg),
    .done    (cyc_done),
    .rdata   (cyc_data),
    .a_out   (FA),
    .dq_out  (FDQ_O),
    .dq_oe   (FDQ_OE),
    .ce_n    (FCE_N),
    .oe_n    (FOE_N),
    .we_n    (FWE_N)
  );
  // ****************************************************************
  // status check sequencer
  // ****************************************************************
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= S_IDLE;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      susp_reg  <= 1'b0;
      first_reg <= 8'h00;
      last_reg  <= 8'h00;
      go_reg    <= 1'b0;
      wr_reg    <= 1'b0;
    end
    else
    begin
      go_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (start_pulse)
          begin
            busy_reg  <= 1'b1;
            done_reg  <= 1'b0;
            fail_reg  <= 1'b0;
            susp_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            go_reg    <= 1'b1;
            state_reg <= S_RD1; // always from the first read
          end
        end
        S_RD1:
        begin
          if (cyc_done)
          begin
            first_reg <= cyc_data;
            go_reg    <= 1'b1;  // same address every read
            state_reg <= S_RD2;
          end
        end
        S_RD2:
        begin
          if (abort_pulse)
          begin
            busy_reg  <= !cyc_done; // stay busy while a read is on the pins
            state_reg <= cyc_done ? S_IDLE : S_WAIT;
          end
          else if (cyc_done)
          begin
            first_reg <= cyc_data;
            go_reg    <= 1'b1; // next read, same address
            if (mode_reg ? (cyc_data[`POLL_BIT] == data_reg[`POLL_BIT])
                         : !tog_one && !tog_two)
            begin
              susp_reg  <= 1'b0;
              state_reg <= S_FINAL; // fresh read for full data
            end
            else if (!mode_reg && !tog_one)
              susp_reg  <= 1'b1; // toggle two alone: suspended
            else if (cyc_data[`TIMEOUT_BIT])
              state_reg <= S_RECHK; // recheck after timeout
            else
              susp_reg  <= 1'b0;
          end
        end
        S_RECHK:
        begin
          if (cyc_done)
          begin
            if (mode_reg ? (cyc_data[`POLL_BIT] == data_reg[`POLL_BIT])
                         : !toggled(first_reg, cyc_data, `TOG1_BIT))
            begin
              go_reg    <= 1'b1;
              state_reg <= S_FINAL;
            end
            else
            begin
              fail_reg  <= 1'b1; // failed
              wr_reg    <= 1'b1;
              go_reg    <= 1'b1; // reset command
              state_reg <= S_RST;
            end
          end
        end
        S_RST:
        begin
          if (cyc_done)
          begin
            wr_reg    <= 1'b0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_FINAL:
        begin
          if (cyc_done)
          begin
            last_reg  <= cyc_data; // valid array data
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_WAIT:
        begin
          busy_reg  <= !cyc_done; // aborted read ends before a new start
          state_reg <= cyc_done ? S_IDLE : S_WAIT;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // wishbone slave, one wait state, ack one cycle
  // ****************************************************************
  wire wb_req = CYC_I && STB_I && !ACK_O;
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ACK_O       <= 1'b0;
      DAT_O       <= 32'h00000000;
      mode_reg    <= 1'b0;
      addr_reg    <= 21'h00000;
      data_reg    <= 8'h00;
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
    end
    else
    begin
      ACK_O       <= wb_req;
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
      DAT_O       <= 32'h00000000;
      if (wb_req && WE_I && SEL_I[0] && !busy_reg)
      begin
        case (ADR_I)
          `REG_CTRL:
          begin
            mode_reg    <= DAT_I[`CTRL_MODE];
            start_pulse <= DAT_I[`CTRL_START];
          end
          `REG_ADDR: addr_reg <= DAT_I[20:0];
          `REG_DATA: data_reg <= DAT_I[7:0];
          default: ;
        endcase
      end
      else if (wb_req && WE_I && SEL_I[0] && ADR_I == `REG_CTRL)
        abort_pulse <= DAT_I[`CTRL_ABORT];
      else if (wb_req && !WE_I)
      begin
        case (ADR_I)
          `REG_CTRL: DAT_O <= {30'h0, mode_reg, 1'b0};
          `REG_ADDR: DAT_O <= {11'h0, addr_reg};
          `REG_DATA: DAT_O <= {24'h0, data_reg};
          `REG_STAT: DAT_O <= {16'h0, last_reg, 3'h0, susp_reg,
                               rb_sync_reg[1], fail_reg, done_reg,
                               busy_reg}; // ready pin seen
          default:   DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== testbench/flash_poll_props.sv ====
`default_nettype none
// ********************
// pin timing checks
// ********************
module flash_poll_props
(
  input wire logic        CLK,    // clock
  input wire logic        NRST,   // reset, active low
  input wire logic        CYC_I,  // bus cycle
  input wire logic        STB_I,  // bus strobe
  input wire logic        ACK_O,  // bus acknowledge
  input wire logic [20:0] FA,     // flash address
  input wire logic [7:0]  FDQ_O,  // flash data out
  input wire logic        FDQ_OE, // flash drive enable
  input wire logic        FCE_N,  // chip enable
  input wire logic        FOE_N,  // output enable
  input wire logic        FWE_N   // write strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // strobe low spans of one read and one write
  sequence rd_low_s;
    (!FOE_N && !FCE_N) [*8];
  endsequence
  sequence wr_low_s;
    (!FWE_N && !FCE_N) [*8];
  endsequence
  ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack late");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  read_len_a: assert property ($fell(FOE_N) |-> rd_low_s ##1 FOE_N)
    else $error("read length");
  read_gap_a: assert property ($rose(FOE_N) |=> FOE_N)
    else $error("no gap between reads");
  write_len_a: assert property ($fell(FWE_N) |-> wr_low_s ##1 FWE_N)
    else $error("write length");
  reset_data_a: assert property (!FWE_N |-> FDQ_OE && FDQ_O == 8'hf0)
    else $error("bad command data");
  read_nodrive_a: assert property (!FOE_N |-> !FDQ_OE && FWE_N)
    else $error("drive during read");
  addr_hold_a: assert property (!FOE_N && !$past(FOE_N) |-> $stable(FA))
    else $error("address moved");
endmodule
`default_nettype wire

// ==== testbench/flash_model.sv ====
`default_nettype none
// ********************
// flash status model
// ********************
module flash_model
(
  input  wire logic        ce_n, // chip enable
  input  wire logic        oe_n, // output enable
  input  wire logic        we_n, // write strobe
  input  wire logic [20:0] a,    // address pins
  input  wire logic [7:0]  din,  // data from host
  output logic      [7:0]  dq,   // data to host
  output logic             rb_n  // ready/busy, pulled up
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        busy = 0, erase = 0, susp = 0, fail = 0, t1 = 0, t2 = 0;
  logic        reset_seen = 0, bad_addr = 0;
  logic [7:0]  data = 8'hff, out = 8'h00;
  logic [20:0] va = 21'h0;
  int          left = 0;
  wire         rd = ce_n | oe_n;
  wire         wr = ce_n | we_n; // a write ends on the first strobe to rise
  // status is live at once; n reads pass before it ends
  task automatic begin_op(input logic e, s, f, input int n,
                          input logic [7:0] d, input logic [20:0] adr);
    busy = 1;
    erase = e;
    susp = s;
    fail = f;
    left = n;
    data = d;
    va = adr;
    t1 = 0;
    t2 = 0;
    reset_seen = 0;
    bad_addr = 0;
  endtask
  // status byte while busy, array data otherwise
  always @(negedge rd)
  begin
    if (busy && a !== va)
      bad_addr = 1;
    if (busy)
      out = {erase ? susp : ~data[7], t1, fail, 2'b00, t2, 2'b00};
    else
      out = data;
  end
  // toggling and progress at the end of each read
  always @(posedge rd)
  begin
    if (busy)
    begin
      t1 = susp ? t1 : ~t1;
      t2 = erase ? ~t2 : t2;
      if (!susp && !fail)
        left = left - 1;
      if (left == 0)
        busy = 0;
    end
  end
  // reset command ends a failed operation
  always @(posedge wr)
  begin
    if (din === 8'hf0)
    begin
      busy = 0;
      fail = 0;
      reset_seen = 1;
    end
  end
  // released bus shows the inverse; pin low only while working
  assign dq = rd ? ~out : out;
  assign rb_n = (busy && !susp) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`include "flash_status_defines.vh"
`default_nettype none
// ********************
// status poller bench
// ********************
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, NRST = 0, WE_I = 0, CYC_I = 0, STB_I = 0;
  logic [3:0]  ADR_I = 4'h0, SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0, rd_q;
  wire  [31:0] DAT_O;
  wire  [20:0] FA;
  wire  [7:0]  FDQ_O, fm_dq;
  wire         ACK_O, FDQ_OE, FCE_N, FOE_N, FWE_N, READY_BUSY_N;
  wire  [7:0]  FDQ_I = FDQ_OE ? FDQ_O : fm_dq;
  int          fail_count = 0, checks_done = 0;
  flash_status_poller u_dut (.CLK(CLK), .NRST(NRST), .ADR_I(ADR_I),
    .DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .FA(FA), .FDQ_O(FDQ_O), .FDQ_OE(FDQ_OE),
    .FDQ_I(FDQ_I), .FCE_N(FCE_N), .FOE_N(FOE_N), .FWE_N(FWE_N),
    .READY_BUSY_N(READY_BUSY_N));
  flash_model u_fm (.ce_n(FCE_N), .oe_n(FOE_N), .we_n(FWE_N), .a(FA),
    .din(FDQ_O), .dq(fm_dq), .rb_n(READY_BUSY_N));
  always #10 CLK = ~CLK;
  // value compare
  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until ack
  task automatic wb_xfer(input logic [3:0] a, input logic w,
                         input logic [31:0] d);
    @(posedge CLK);
    ADR_I <= a;
    WE_I <= w;
    DAT_I <= d;
    SEL_I <= 4'hf;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    do
      @(posedge CLK);
    while (ACK_O !== 1'b1);
    rd_q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask
  // poll status until a bit reaches a level
  task automatic wait_bit(input int b, input logic v);
    do
      wb_xfer(`REG_STAT, 1'b0, 32'h0);
    while (rd_q[b] !== v);
  endtask
  // start an operation and see it finish
  task automatic run_op(input logic mode, e, input int n,
                        input logic [7:0] d);
    u_fm.begin_op(e, 1'b0, 1'b0, n, d, 21'h01a5a5);
    wb_xfer(`REG_ADDR, 1'b1, 32'h0001a5a5);
    wb_xfer(`REG_DATA, 1'b1, {24'h0, d});
    wb_xfer(`REG_CTRL, 1'b1, {30'h0, mode, 1'b1});
    wb_xfer(`REG_STAT, 1'b0, 32'h0);
    check(rd_q & 32'h9, 32'h1);
    wait_bit(`STAT_BUSY, 1'b0);
    check(rd_q & 32'hff1f, {16'h0, d, 8'h0a});
    check({31'h0, u_fm.bad_addr}, 32'h0);
  endtask
  task automatic t_reset();
    wb_xfer(`REG_STAT, 1'b0, 32'h0);
    check(rd_q & 32'hff1f, 32'h8);
    wb_xfer(4'h1, 1'b0, 32'h0);
    check(rd_q, 32'h0);
  endtask
  task automatic t_suspend();
    u_fm.begin_op(1'b1, 1'b1, 1'b0, 1, 8'hff, 21'h01a5a5);
    wb_xfer(`REG_CTRL, 1'b1, 32'h1);
    wait_bit(`STAT_SUSP, 1'b1);
    check(rd_q & 32'h1f, 32'h19);
    wb_xfer(`REG_CTRL, 1'b1, 32'h4);
    wait_bit(`STAT_BUSY, 1'b0);
    check(rd_q & 32'h1, 32'h0);
  endtask
  task automatic t_fail();
    u_fm.begin_op(1'b0, 1'b0, 1'b1, 1, 8'h77, 21'h01a5a5);
    wb_xfer(`REG_CTRL, 1'b1, 32'h1);
    wait_bit(`STAT_BUSY, 1'b0);
    check(rd_q & 32'hf, 32'he);
    check({31'h0, u_fm.reset_seen}, 32'h1);
  endtask
  // verdict and end of run
  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    run_op(1'b0, 1'b0, 5, 8'h5a);
    run_op(1'b1, 1'b0, 4, 8'ha5);
    run_op(1'b0, 1'b1, 6, 8'hff);
    run_op(1'b1, 1'b1, 3, 8'hff);
    run_op(1'b0, 1'b0, 1, 8'h3c);
    t_suspend();
    t_fail();
    complete_run();
  end
  // watchdog
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule
bind flash_status_poller flash_poll_props u_props (.CLK(CLK), .NRST(NRST),
  .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .FA(FA), .FDQ_O(FDQ_O),
  .FDQ_OE(FDQ_OE), .FCE_N(FCE_N), .FOE_N(FOE_N), .FWE_N(FWE_N));
`default_nettype wire
